// file: rtl/srt_defines.svh
`ifndef SRT_DEFINES_SVH
`define SRT_DEFINES_SVH

// register addresses
`define SRT_ADDR_CONTROL 8'hc8
`define SRT_ADDR_RELOAD_LOW 8'hca
`define SRT_ADDR_RELOAD_HIGH 8'hcb
`define SRT_ADDR_COUNT_LOW 8'hcc
`define SRT_ADDR_COUNT_HIGH 8'hcd

// control fields
`define SRT_BIT_HIGH_FLAG 7
`define SRT_BIT_LOW_FLAG 6
`define SRT_BIT_LOW_IRQ_EN 5
`define SRT_BIT_CAPTURE_EN 4
`define SRT_BIT_SPLIT 3
`define SRT_BIT_RUN 2
`define SRT_BIT_CAP_SRC 1
`define SRT_BIT_EXT_SEL 0

// clock control fields
`define SRT_BIT_HIGH_CLK_SEL 5
`define SRT_BIT_LOW_CLK_SEL 4

// reset values
`define SRT_RESET_BYTE 8'h00

// timing counts
`define SRT_SYS_DIV 12
`define SRT_OSC_DIV 8

`endif

// file: rtl/srt_pkg.sv
package srt_pkg;
  typedef logic [7:0] srt_byte_t;
  typedef enum logic [1:0] {
    SRT_SRC_SYS,
    SRT_SRC_DIV12,
    SRT_SRC_OSC_A,
    SRT_SRC_OSC_B
  } srt_src_t;
endpackage

// file: rtl/srt_osc_tick.sv
`timescale 1ns/1ps
// ****************************************
// oscillator to system clock tick, div by 8
// ****************************************
module srt_osc_tick #(
  parameter int DIV = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // oscillator level
  input wire logic i_osc,
  // one system cycle per DIV oscillator rises
  output logic o_tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic [W-1:0] count;
  logic rise;

  // refuse a divider the counter cannot serve
  if (DIV < 2)
  begin : g_bad_div
    $error("DIV must be at least 2");
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      sync_a <= i_osc;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign rise = sync_b & ~sync_c;

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      if (rise)
      begin
        if (count == W'(DIV - 1))
        begin
          count <= '0;
          o_tick <= 1'b1;
        end
        else
        begin
          count <= count + W'(1);
        end
      end
    end
  end
endmodule // srt_osc_tick

// file: rtl/srt_div_tick.sv
`timescale 1ns/1ps
// ****************************************
// system clock prescaler tick
// ****************************************
module srt_div_tick #(
  parameter int DIV = 12
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // one cycle every DIV
  output logic o_tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] count;

  // refuse a divider the counter cannot serve
  if (DIV < 2)
  begin : g_bad_div
    $error("DIV must be at least 2");
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count <= '0;
      o_tick <= 1'b0;
    end
    else if (count == W'(DIV - 1))
    begin
      count <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      count <= count + W'(1);
      o_tick <= 1'b0;
    end
  end
endmodule // srt_div_tick

// file: rtl/srt_timer.sv
`timescale 1ns/1ps
`include "srt_defines.svh"
module srt_timer (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output srt_pkg::srt_byte_t o_rdata,
  // system register bits
  input wire logic [7:0] i_clock_control_register,
  input wire logic i_timer_irq_enable,
  // oscillators
  input wire logic i_ext_osc,
  input wire logic i_rtc_osc,
  // interrupt request
  output logic o_irq
);
  import srt_pkg::*;

  // ****************************************
  // state
  // ****************************************
  srt_byte_t count_low_byte;
  srt_byte_t count_high_byte;
  srt_byte_t reload_low;
  srt_byte_t reload_high;
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_irq_enable;
  logic capture_enable;
  logic split_mode;
  logic run_control;
  logic capture_source_select;
  logic external_clock_select;
  logic high_byte_clock_select;
  logic low_byte_clock_select;
  logic tick_div12;
  logic tick_ext;
  logic tick_rtc;
  logic tick_count_osc;
  logic tick_capture;
  logic tick_ext_sel;
  logic tick_low;
  logic tick_high;
  logic inc_low;
  logic inc_high;
  logic wrap_low;
  logic wrap_high;
  logic capture;
  logic wr_control;
  srt_src_t src_low;
  srt_src_t src_high;

  assign high_byte_clock_select =
    i_clock_control_register[`SRT_BIT_HIGH_CLK_SEL];
  assign low_byte_clock_select =
    i_clock_control_register[`SRT_BIT_LOW_CLK_SEL];

  // ****************************************
  // tick sources
  // ****************************************
  srt_div_tick #(
    .DIV(`SRT_SYS_DIV)
  ) u_div12 (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .o_tick(tick_div12)
  );

  srt_osc_tick #(
    .DIV(`SRT_OSC_DIV)
  ) u_ext_tick (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_osc(i_ext_osc),
    .o_tick(tick_ext)
  );

  srt_osc_tick #(
    .DIV(`SRT_OSC_DIV)
  ) u_rtc_tick (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_osc(i_rtc_osc),
    .o_tick(tick_rtc)
  );

  // ****************************************
  // clock selection
  // ****************************************
  // source 0 counts external, captures rtc; 1 the reverse
  assign tick_count_osc = capture_source_select ? tick_rtc : tick_ext;
  assign tick_capture = capture_source_select ? tick_ext : tick_rtc;
  assign tick_ext_sel = external_clock_select ? tick_count_osc
                                              : tick_div12;

  always_comb
  begin
    if (low_byte_clock_select)
    begin
      src_low = SRT_SRC_SYS;
    end
    else if (!external_clock_select)
    begin
      src_low = SRT_SRC_DIV12;
    end
    else if (capture_source_select)
    begin
      src_low = SRT_SRC_OSC_B;
    end
    else
    begin
      src_low = SRT_SRC_OSC_A;
    end
  end

  // high select only counts in split mode
  always_comb
  begin
    if (split_mode && high_byte_clock_select)
    begin
      src_high = SRT_SRC_SYS;
    end
    else if (split_mode && !external_clock_select)
    begin
      src_high = SRT_SRC_DIV12;
    end
    else if (split_mode)
    begin
      src_high = capture_source_select ? SRT_SRC_OSC_B
                                       : SRT_SRC_OSC_A;
    end
    else
    begin
      src_high = src_low;
    end
  end

  assign tick_low = (src_low == SRT_SRC_SYS) ? 1'b1 : tick_ext_sel;
  assign tick_high = (src_high == SRT_SRC_SYS) ? 1'b1 : tick_ext_sel;

  // ****************************************
  // count enables and wraps
  // ****************************************
  always_comb
  begin
    if (split_mode)
    begin
      inc_low = tick_low;
      inc_high = tick_high & run_control;
    end
    else
    begin
      inc_low = tick_low & run_control;
      inc_high = inc_low & (count_low_byte == 8'hff);
    end
  end

  assign wrap_low = inc_low & (count_low_byte == 8'hff);
  assign wrap_high = inc_high & (count_high_byte == 8'hff);
  assign capture = capture_enable & tick_capture;
  assign wr_control = i_wr & (i_addr == `SRT_ADDR_CONTROL);

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count_low_byte <= `SRT_RESET_BYTE;
    end
    else if (i_wr && i_addr == `SRT_ADDR_COUNT_LOW)
    begin
      count_low_byte <= i_wdata;
    end
    else if (!split_mode && wrap_low && wrap_high)
    begin
      count_low_byte <= reload_low;
    end
    else if (split_mode && wrap_low)
    begin
      count_low_byte <= reload_low;
    end
    else if (inc_low)
    begin
      count_low_byte <= count_low_byte + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count_high_byte <= `SRT_RESET_BYTE;
    end
    else if (i_wr && i_addr == `SRT_ADDR_COUNT_HIGH)
    begin
      count_high_byte <= i_wdata;
    end
    else if (wrap_high)
    begin
      count_high_byte <= reload_high;
    end
    else if (inc_high)
    begin
      count_high_byte <= count_high_byte + 8'h01;
    end
  end

  // ****************************************
  // reload registers
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      reload_low <= `SRT_RESET_BYTE;
      reload_high <= `SRT_RESET_BYTE;
    end
    else if (capture)
    begin
      reload_low <= count_low_byte;
      reload_high <= count_high_byte;
    end
    else if (i_wr)
    begin
      if (i_addr == `SRT_ADDR_RELOAD_LOW)
      begin
        reload_low <= i_wdata;
      end
      if (i_addr == `SRT_ADDR_RELOAD_HIGH)
      begin
        reload_high <= i_wdata;
      end
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      low_irq_enable <= 1'b0;
      capture_enable <= 1'b0;
      split_mode <= 1'b0;
      run_control <= 1'b0;
      capture_source_select <= 1'b0;
      external_clock_select <= 1'b0;
    end
    else if (wr_control)
    begin
      low_irq_enable <= i_wdata[`SRT_BIT_LOW_IRQ_EN];
      capture_enable <= i_wdata[`SRT_BIT_CAPTURE_EN];
      split_mode <= i_wdata[`SRT_BIT_SPLIT];
      run_control <= i_wdata[`SRT_BIT_RUN];
      capture_source_select <= i_wdata[`SRT_BIT_CAP_SRC];
      external_clock_select <= i_wdata[`SRT_BIT_EXT_SEL];
    end
  end

  // set wins over a software write in the same cycle
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
    end
    else
    begin
      if (wrap_high || capture)
      begin
        high_overflow_flag <= 1'b1;
      end
      else if (wr_control)
      begin
        high_overflow_flag <= i_wdata[`SRT_BIT_HIGH_FLAG];
      end
      if (wrap_low)
      begin
        low_overflow_flag <= 1'b1;
      end
      else if (wr_control)
      begin
        low_overflow_flag <= i_wdata[`SRT_BIT_LOW_FLAG];
      end
    end
  end

  // ****************************************
  // interrupt and read back
  // ****************************************
  // level request, gated by i_timer_irq_enable, while the high flag, or the low flag with low_irq_enable set, is pending
  assign o_irq = i_timer_irq_enable
    & (high_overflow_flag
       | (low_irq_enable & low_overflow_flag));

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rdata <= `SRT_RESET_BYTE;
    end
    else
    begin
      unique case (i_addr)
        `SRT_ADDR_CONTROL: o_rdata <= {high_overflow_flag,
          low_overflow_flag, low_irq_enable, capture_enable,
          split_mode, run_control, capture_source_select,
          external_clock_select};
        `SRT_ADDR_RELOAD_LOW: o_rdata <= reload_low;
        `SRT_ADDR_RELOAD_HIGH: o_rdata <= reload_high;
        `SRT_ADDR_COUNT_LOW: o_rdata <= count_low_byte;
        `SRT_ADDR_COUNT_HIGH: o_rdata <= count_high_byte;
        default: o_rdata <= 8'h00;
      endcase
    end
  end
endmodule // srt_timer

// file: verif/srt_timer_assertions.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module srt_timer_assertions (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire srt_pkg::srt_byte_t o_rdata,
  input wire logic [7:0] i_clock_control_register,
  input wire logic i_timer_irq_enable,
  input wire logic i_ext_osc,
  input wire logic i_rtc_osc,
  input wire logic o_irq
);
  import srt_pkg::*;
  logic [7:0] ctl;
  logic [7:0] rl;
  wire unm = !(i_addr inside {8'hc8, [8'hca:8'hcd]});
  wire ml = i_clock_control_register[4];
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      ctl <= 8'h00;
    else if (i_wr && i_addr == 8'hc8)
      ctl <= i_wdata;
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      rl <= 8'h00;
    else if (i_wr && i_addr == 8'hca)
      rl <= i_wdata;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  irq_gate_a: assert property (!i_timer_irq_enable |-> !o_irq)
    else $error("irq without enable");
  unmapped_read_a: assert property ($past(unm) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctl_read_a: assert property ($past(i_addr) == 8'hc8 && !$past(i_wr)
    |-> o_rdata[5:0] == ctl[5:0]) else $error("control bits wrong");
  flag_hold_a: assert property ($past(i_addr) == 8'hc8 &&
    !$past(i_wr) && i_addr == 8'hc8 && !i_wr |=> ((o_rdata &
    $past(o_rdata)) & 8'hc0) == ($past(o_rdata) & 8'hc0))
    else $error("flag cleared by hardware");
  irq_hold_a: assert property (o_irq && !i_wr ##1
    i_timer_irq_enable |-> o_irq) else $error("irq dropped");
  rw_back_a: assert property (i_wr && i_addr inside {[8'hca:8'hcd]}
    && ctl[4:2] == 3'b000 ##1 i_addr == $past(i_addr) && !i_wr
    |=> o_rdata == $past(i_wdata, 2)) else $error("readback wrong");
  frozen_a: assert property (ctl[4:2] == 3'b000 && !i_wr &&
    i_addr inside {8'hcc, 8'hcd} && $past(i_addr) == i_addr &&
    !$past(i_wr) |=> $stable(o_rdata)) else $error("stopped count moved");
  split_low_a: assert property (ctl[4:2] == 3'b010 && ml &&
    $past(ml) && i_addr == 8'hcc && $past(i_addr) == 8'hcc && !i_wr
    && !$past(i_wr) |=> o_rdata == ($past(o_rdata) == 8'hff ? rl :
    $past(o_rdata) + 8'h01)) else $error("split low count wrong");
endmodule // srt_timer_assertions

// file: verif/tb_srt_timer.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_srt_timer;
  import srt_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic i_wr = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_clock_control_register = 8'h10;
  logic i_timer_irq_enable = 1'b1;
  logic i_ext_osc = 1'b0;
  logic i_rtc_osc = 1'b0;
  srt_byte_t o_rdata;
  logic o_irq;
  logic [31:0] seed = 32'h5456d019;
  logic [7:0] v, r, x;
  int err_count = 0;
  int n_compared = 0;
  srt_timer DUT (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_addr(i_addr),
    .i_wr(i_wr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .i_clock_control_register(i_clock_control_register),
    .i_timer_irq_enable(i_timer_irq_enable),
    .i_ext_osc(i_ext_osc),
    .i_rtc_osc(i_rtc_osc),
    .o_irq(o_irq)
  );
  initial
  forever #20 i_mclk = ~i_mclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(negedge i_mclk) i_ext_osc <= ^xs();
  task chk(input string n, input logic [7:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(negedge i_mclk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_mclk);
    i_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge i_mclk);
    i_addr = a;
    @(negedge i_mclk);
    r = o_rdata;
  endtask
  task rc(input string n, input logic [7:0] a, e);
    rd(a);
    chk(n, r, e);
  endtask
  task ic(input logic e);
    chk("irq", {7'h00, o_irq}, {7'h00, e});
  endtask
  task osc(input int n);
    repeat (n)
    begin
      i_rtc_osc = 1'b1;
      repeat (4) @(negedge i_mclk);
      i_rtc_osc = 1'b0;
      repeat (4) @(negedge i_mclk);
    end
  endtask
  task wrap_up;
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge i_mclk);
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (21) @(negedge i_mclk);
    i_arst_n = 1'b1;
    for (int a = 8'hc8; a < 8'hd0; a++)
      rc("reset", 8'(a), 8'h00);
    repeat (8)
    begin
      v = 8'(xs());
      x = 8'hca + 8'(xs() & 3);
      wr(x, v);
      rc("rw", x, v);
    end
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    repeat (4) @(negedge i_mclk);
    repeat (2) rc("flags", 8'hc8, 8'hc4);
    rc("reload", 8'hcd, 8'h12);
    ic(1'b1);
    i_timer_irq_enable = 1'b0;
    #5 ic(1'b0);
    @(negedge i_mclk);
    i_timer_irq_enable = 1'b1;
    wr(8'hc8, 8'h00);
    ic(1'b0);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h24);
    repeat (4) @(negedge i_mclk);
    rc("lowflag", 8'hc8, 8'h64);
    ic(1'b1);
    wr(8'hc8, 8'h44);
    ic(1'b0);
    wr(8'hc8, 8'h00);
    rc("carry", 8'hcd, 8'h01);
    v = 8'(xs()) & 8'h7f;
    i_clock_control_register = 8'h30;
    wr(8'hca, v);
    wr(8'hcd, 8'h77);
    wr(8'hcc, 8'hfe);
    wr(8'hc8, 8'h08);
    repeat (3) rd(8'hcc);
    rc("split", 8'hc8, 8'h48);
    rc("hold", 8'hcd, 8'h77);
    ic(1'b0);
    wr(8'hcb, 8'h5a);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h0c);
    repeat (4) @(negedge i_mclk);
    rc("splithi", 8'hc8, 8'h8c);
    ic(1'b1);
    i_clock_control_register = 8'h10;
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h14);
    osc(7);
    rc("cap7", 8'hc8, 8'h14);
    osc(1);
    repeat (6) @(negedge i_mclk);
    rc("cap8", 8'hc8, 8'h94);
    rc("caphi", 8'hcb, 8'h00);
    i_clock_control_register = 8'h00;
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h04);
    repeat (60) @(negedge i_mclk);
    wr(8'hc8, 8'h00);
    rd(8'hcc);
    chk("div12", {7'h00, r inside {[8'h04:8'h06]}}, 8'h01);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h07);
    osc(16);
    rc("rtc8", 8'hcc, 8'h02);
    wrap_up();
  end
endmodule // tb_srt_timer
bind srt_timer srt_timer_assertions u_chk (
  .i_mclk(i_mclk),
  .i_arst_n(i_arst_n),
  .i_addr(i_addr),
  .i_wr(i_wr),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .i_clock_control_register(i_clock_control_register),
  .i_timer_irq_enable(i_timer_irq_enable),
  .i_ext_osc(i_ext_osc),
  .i_rtc_osc(i_rtc_osc),
  .o_irq(o_irq)
);
